// ===== logic/llsm_defs.vh
// constants for the load limit and status monitor
// What this block does
// - duty setting accepted only from 1 to 99 percent (0.01 to 0.99)
// - with dimming rate at DC, duty commands are invalid and ignored
// - a lower bound is never held above its matching upper bound
// - in current or resistance mode, current outside its bounds flags violation
// - in power or resistance mode, power outside its bounds flags violation
// - terminal voltage outside its bounds flags violation
// - a quantity inside its bounds inclusive raises no violation
// - during shorting test, voltage outside crowbar bounds flags violation
// - load state reads 0 off, 1 on
// - mode reads 0 current, 1 resistance, 2 voltage, 3 power, 4 LED
// - shorting status reads 0 active, 1 inactive
// - preset state reads 0 off, 1 on
// - sense accepts on, off, auto; reads 1 only for on
// - constant modes hold two levels; level reads 0 low, 1 high
// - dynamic state reads 0 dynamic, 1 static
// - wipe command zeroes both trip and fault registers, save bits whose event arrives in the same cycle
// - fault bits 0-3 channel one, 4 operation, 5 command error
// - pass/fail reads 1 with fail lamp lit while violation present
// - trip bits: 0 over-power, 1 over-temp, 2 over-voltage, 3 over-current
`ifndef LLSM_DEFS_VH
`define LLSM_DEFS_VH
`define LLSM_VW 16
`define LLSM_DUTY_MIN 7'h01
`define LLSM_DUTY_MAX 7'h63
`define LLSM_DUTY_RST 7'h32
`define LLSM_MODE_CC 3'h0
`define LLSM_MODE_CR 3'h1
`define LLSM_MODE_CV 3'h2
`define LLSM_MODE_CP 3'h3
`define LLSM_MODE_LED 3'h4
`define LLSM_SENSE_OFF 2'h0
`define LLSM_SENSE_ON 2'h1
`define LLSM_SENSE_AUTO 2'h2
`define LLSM_SEL_CUR 2'h0
`define LLSM_SEL_PWR 2'h1
`define LLSM_SEL_VLT 2'h2
`define LLSM_SEL_SHT 2'h3
`define LLSM_ERR_CH1_LSB 0
`define LLSM_ERR_OP_BIT 4
`define LLSM_ERR_CMD_BIT 5
`define LLSM_SAFEGUARD_TRIP_REGISTER_OPP_BIT 0
`define LLSM_SAFEGUARD_TRIP_REGISTER_OTP_BIT 1
`define LLSM_SAFEGUARD_TRIP_REGISTER_OVP_BIT 2
`define LLSM_SAFEGUARD_TRIP_REGISTER_OCP_BIT 3
`define LLSM_FAULT_RST 6'h00
`define LLSM_TRIP_RST 4'h0
`define LLSM_LOW_RST 16'h0000
`define LLSM_HIGH_RST 16'hFFFF
`endif

// ===== logic/llsm_window.v
// one limit pair with its out-of-window compare
`timescale 1ns/1ps
`default_nettype none
`include "llsm_defs.vh"
module llsm_window (
	input wire ref_clk,
	input wire rst,
	input wire ce,
	input wire wr_low,
	input wire wr_high,
	input wire [15:0] wr_data,
	input wire [15:0] meas,
	output reg [15:0] low_r,
	output reg [15:0] high_r,
	output reg outside_r
);
	always @(posedge ref_clk) begin
		if (rst) begin
			low_r <= `LLSM_LOW_RST;
			high_r <= `LLSM_HIGH_RST;
			outside_r <= 1'b0;
		end else if (ce) begin
			// an order that would cross the pair is dropped
			if (wr_low && wr_data <= high_r)
				low_r <= wr_data;
			if (wr_high && wr_data >= low_r)
				high_r <= wr_data;
			// bounds themselves count as inside
			outside_r <= (meas < low_r) || (meas > high_r);
		end
	end
endmodule // llsm_window
`default_nettype wire

// ===== logic/llsm_sticky.v
// sticky flag register, set beats clear
`timescale 1ns/1ps
`default_nettype none
module llsm_sticky #(
	parameter W = 6
) (
	input wire ref_clk,
	input wire rst,
	input wire ce,
	input wire clr,
	input wire [W-1:0] set,
	output reg [W-1:0] flags_r
);
	always @(posedge ref_clk) begin
		if (rst)
			flags_r <= {W{1'b0}};
		else if (ce)
			flags_r <= (clr ? {W{1'b0}} : flags_r) | set;
	end
endmodule // llsm_sticky
`default_nettype wire

// ===== logic/llsm_monitor.v
// load limit and status monitor top
`timescale 1ns/1ps
`default_nettype none
`include "llsm_defs.vh"
module llsm_monitor (
	input wire ref_clk,
	input wire rst,
	input wire ce,
	input wire [1:0] bound_sel,
	input wire bound_low_wr,
	input wire bound_high_wr,
	input wire [15:0] bound_data,
	input wire duty_wr,
	input wire [6:0] duty_data,
	input wire dimming_rate_dc,
	input wire [15:0] meas_current,
	input wire [15:0] meas_power,
	input wire [15:0] meas_voltage,
	input wire load_on_wr,
	input wire load_on_data,
	input wire mode_wr,
	input wire [2:0] mode_data,
	input wire short_wr,
	input wire short_data,
	input wire preset_wr,
	input wire preset_data,
	input wire sense_wr,
	input wire [1:0] sense_data,
	input wire level_wr,
	input wire level_data,
	input wire dyn_wr,
	input wire dyn_data,
	input wire flag_wipe_command,
	input wire [3:0] ch1_err_evt,
	input wire op_err_evt,
	input wire cmd_err_evt,
	input wire [3:0] trip_evt,
	output reg [6:0] duty_r,
	output reg duty_reject_r,
	output reg load_state_r,
	output reg [2:0] mode_state_r,
	output reg short_state_r,
	output reg preset_state_r,
	output reg sense_state_r,
	output reg [1:0] sense_setting_r,
	output reg level_state_r,
	output reg dyn_state_r,
	output reg limit_violation_flag,
	output reg fail_lamp_r,
	output wire [5:0] fault_flag_register,
	output wire [3:0] safeguard_trip_register,
	output wire [15:0] current_lower_bound,
	output wire [15:0] current_upper_bound,
	output wire [15:0] power_lower_bound,
	output wire [15:0] power_upper_bound,
	output wire [15:0] voltage_lower_bound,
	output wire [15:0] voltage_upper_bound,
	output wire [15:0] crowbar_volt_floor,
	output wire [15:0] crowbar_volt_ceiling
);
	wire cur_out;
	wire pwr_out;
	wire vlt_out;
	wire sht_out;
	wire shorting;
	wire cur_mode;
	wire pwr_mode;
	wire flag_nxt;
	wire [5:0] fault_set;

	function sel_hit;
		input [1:0] sel;
		input [1:0] want;
		sel_hit = (sel == want);
	endfunction

	llsm_window u_cur (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.wr_low(bound_low_wr & sel_hit(bound_sel, `LLSM_SEL_CUR)),
		.wr_high(bound_high_wr & sel_hit(bound_sel, `LLSM_SEL_CUR)),
		.wr_data(bound_data),
		.meas(meas_current),
		.low_r(current_lower_bound),
		.high_r(current_upper_bound),
		.outside_r(cur_out)
	);
	llsm_window u_pwr (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.wr_low(bound_low_wr & sel_hit(bound_sel, `LLSM_SEL_PWR)),
		.wr_high(bound_high_wr & sel_hit(bound_sel, `LLSM_SEL_PWR)),
		.wr_data(bound_data),
		.meas(meas_power),
		.low_r(power_lower_bound),
		.high_r(power_upper_bound),
		.outside_r(pwr_out)
	);
	llsm_window u_vlt (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.wr_low(bound_low_wr & sel_hit(bound_sel, `LLSM_SEL_VLT)),
		.wr_high(bound_high_wr & sel_hit(bound_sel, `LLSM_SEL_VLT)),
		.wr_data(bound_data),
		.meas(meas_voltage),
		.low_r(voltage_lower_bound),
		.high_r(voltage_upper_bound),
		.outside_r(vlt_out)
	);
	llsm_window u_sht (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.wr_low(bound_low_wr & sel_hit(bound_sel, `LLSM_SEL_SHT)),
		.wr_high(bound_high_wr & sel_hit(bound_sel, `LLSM_SEL_SHT)),
		.wr_data(bound_data),
		.meas(meas_voltage),
		.low_r(crowbar_volt_floor),
		.high_r(crowbar_volt_ceiling),
		.outside_r(sht_out)
	);

	// short status is stored as read back: 0 means the test runs
	assign shorting = ~short_state_r;
	assign cur_mode = (mode_state_r == `LLSM_MODE_CC) ||
		(mode_state_r == `LLSM_MODE_CR);
	assign pwr_mode = (mode_state_r == `LLSM_MODE_CP) ||
		(mode_state_r == `LLSM_MODE_CR);
	assign flag_nxt = (cur_mode & cur_out) |
		(pwr_mode & pwr_out) |
		vlt_out |
		(shorting & sht_out);

	assign fault_set = {cmd_err_evt, op_err_evt, ch1_err_evt};

	llsm_sticky #(.W(6)) u_fault (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.clr(flag_wipe_command),
		.set(fault_set),
		.flags_r(fault_flag_register)
	);
	llsm_sticky #(.W(4)) u_trip (
		.ref_clk(ref_clk),
		.rst(rst),
		.ce(ce),
		.clr(flag_wipe_command),
		.set(trip_evt),
		.flags_r(safeguard_trip_register)
	);

	always @(posedge ref_clk) begin
		if (rst) begin
			duty_r <= `LLSM_DUTY_RST;
			duty_reject_r <= 1'b0;
			load_state_r <= 1'b0;
			mode_state_r <= `LLSM_MODE_CC;
			short_state_r <= 1'b1;
			preset_state_r <= 1'b0;
			sense_state_r <= 1'b0;
			sense_setting_r <= `LLSM_SENSE_OFF;
			level_state_r <= 1'b0;
			dyn_state_r <= 1'b1;
			limit_violation_flag <= 1'b0;
			fail_lamp_r <= 1'b0;
		end else if (ce) begin
			duty_reject_r <= 1'b0;
			if (duty_wr) begin
				if (dimming_rate_dc)
					duty_reject_r <= 1'b1;
				else if (duty_data >= `LLSM_DUTY_MIN &&
					duty_data <= `LLSM_DUTY_MAX)
					duty_r <= duty_data;
				else
					duty_reject_r <= 1'b1;
			end
			if (load_on_wr)
				load_state_r <= load_on_data;
			// unknown mode codes are ignored
			if (mode_wr && mode_data <= `LLSM_MODE_LED)
				mode_state_r <= mode_data;
			if (short_wr)
				short_state_r <= ~short_data;
			if (preset_wr)
				preset_state_r <= preset_data;
			if (sense_wr && sense_data != 2'h3) begin
				sense_setting_r <= sense_data;
				sense_state_r <= (sense_data == `LLSM_SENSE_ON);
			end
			// LED mode has no two-level setpoint
			if (level_wr && mode_state_r != `LLSM_MODE_LED)
				level_state_r <= level_data;
			if (dyn_wr)
				dyn_state_r <= ~dyn_data;
			limit_violation_flag <= flag_nxt;
			fail_lamp_r <= flag_nxt;
		end
	end
endmodule // llsm_monitor
`default_nettype wire

// ===== dv/llsm_host.sv
// remote host model: one-cycle command pulses
`timescale 1ns/1ps
`default_nettype none
module llsm_host (
	input wire logic ref_clk,
	output logic [10:0] wr,
	output logic [1:0] sel,
	output logic [15:0] dat
);
	initial begin
		wr = 11'h000;
		sel = 2'h0;
		dat = 16'h0000;
	end
	// released data is inverted so a stale value never passes
	task automatic cmd(input int k, input logic [1:0] s, input logic [15:0] v);
		@(posedge ref_clk);
		#1;
		wr[k] = 1'b1;
		sel = s;
		dat = v;
		@(posedge ref_clk);
		#1;
		wr = 11'h000;
		dat = ~v;
	endtask
endmodule // llsm_host
`default_nettype wire

// ===== dv/llsm_monitor_chk.sv
// port assertions for the monitor
`timescale 1ns/1ps
`default_nettype none
module llsm_chk (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic duty_wr,
	input wire logic [6:0] duty_data,
	input wire logic dimming_rate_dc,
	input wire logic [6:0] duty_r,
	input wire logic duty_reject_r,
	input wire logic [15:0] meas_voltage,
	input wire logic [15:0] voltage_lower_bound,
	input wire logic [15:0] voltage_upper_bound,
	input wire logic limit_violation_flag,
	input wire logic fail_lamp_r,
	input wire logic flag_wipe_command,
	input wire logic [3:0] ch1_err_evt,
	input wire logic op_err_evt,
	input wire logic cmd_err_evt,
	input wire logic [5:0] fault_flag_register
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	wire [5:0] ev = {cmd_err_evt, op_err_evt, ch1_err_evt};
	wire v_out = meas_voltage < voltage_lower_bound ||
		meas_voltage > voltage_upper_bound;
	AST_DUTY_OK: assert property (ce && duty_wr && !dimming_rate_dc &&
		duty_data >= 7'h01 && duty_data <= 7'h63 |=> duty_r == $past(duty_data))
		else $error("duty not taken");
	AST_DUTY_BAD: assert property (ce && duty_wr && (dimming_rate_dc ||
		duty_data == 7'h00 || duty_data > 7'h63) |=> $stable(duty_r))
		else $error("bad duty taken");
	AST_DUTY_REJ: assert property (ce && duty_wr && dimming_rate_dc
		|=> duty_reject_r) else $error("dc duty not refused");
	AST_ORDER: assert property (voltage_lower_bound <= voltage_upper_bound)
		else $error("bounds crossed");
	AST_VOUT: assert property (ce && v_out ##1 ce |=> limit_violation_flag)
		else $error("voltage violation missed");
	AST_LAMP: assert property (fail_lamp_r == limit_violation_flag)
		else $error("lamp differs from flag");
	AST_WIPE: assert property (ce && flag_wipe_command && ev == 6'h00
		|=> fault_flag_register == 6'h00) else $error("wipe failed");
	AST_SET: assert property (ce |=>
		(fault_flag_register & $past(ev)) == $past(ev)) else $error("fault lost");
	AST_HOLD: assert property (ce && !flag_wipe_command |=>
		(fault_flag_register & $past(fault_flag_register)) ==
		$past(fault_flag_register)) else $error("fault dropped");
endmodule // llsm_chk
`default_nettype wire

// ===== dv/tb_load_limit_status_monitor.sv
// bench for the limit and status monitor
`timescale 1ns/1ps
`default_nettype none
module tb_load_limit_status_monitor;
	typedef struct {int i; logic [15:0] e;} llsm_note;
	logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, dc = 1'b0;
	logic [15:0] mc = 16'h0000, mp = 16'h0000, mv = 16'h0000, rn = 16'h55FE;
	logic [9:0] ev = 10'h000, ef = 10'h000;
	logic [15:0] tab [9] = '{16'h3111, 16'h3010, 16'h5130, 16'h6141,
		16'h7151, 16'h7250, 16'h8161, 16'h9170, 16'h9071};
	int bad_count = 0, compares = 0, cyc = 0;
	llsm_note q[$];
	llsm_note nt;
	wire [10:0] wr;
	wire [1:0] sel;
	wire [15:0] d;
	tri0 [11:0][15:0] ob;
	always #50 ref_clk = ~ref_clk;
	llsm_host host (.ref_clk, .wr, .sel, .dat(d));
	llsm_monitor dut (.ref_clk, .rst, .ce, .bound_sel(sel),
		.bound_low_wr(wr[0]), .bound_high_wr(wr[1]), .bound_data(d),
		.duty_wr(wr[2]), .duty_data(d[6:0]), .dimming_rate_dc(dc),
		.meas_current(mc), .meas_power(mp), .meas_voltage(mv),
		.load_on_wr(wr[3]), .load_on_data(d[0]), .mode_wr(wr[4]),
		.mode_data(d[2:0]), .short_wr(wr[5]), .short_data(d[0]),
		.preset_wr(wr[6]), .preset_data(d[0]), .sense_wr(wr[7]),
		.sense_data(d[1:0]), .level_wr(wr[8]), .level_data(d[0]),
		.dyn_wr(wr[9]), .dyn_data(d[0]), .flag_wipe_command(wr[10]),
		.ch1_err_evt(ev[3:0]), .op_err_evt(ev[4]), .cmd_err_evt(ev[5]),
		.trip_evt(ev[9:6]), .duty_r(ob[0][6:0]), .duty_reject_r(),
		.load_state_r(ob[1][0]), .mode_state_r(ob[2][2:0]),
		.short_state_r(ob[3][0]), .preset_state_r(ob[4][0]),
		.sense_state_r(ob[5][0]), .sense_setting_r(), .level_state_r(ob[6][0]),
		.dyn_state_r(ob[7][0]), .limit_violation_flag(ob[8][0]),
		.fail_lamp_r(), .fault_flag_register(ob[9][5:0]),
		.safeguard_trip_register(ob[10][3:0]), .current_lower_bound(),
		.current_upper_bound(), .power_lower_bound(), .power_upper_bound(),
		.voltage_lower_bound(ob[11]), .voltage_upper_bound(),
		.crowbar_volt_floor(), .crowbar_volt_ceiling());
	function automatic logic [15:0] nx(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic w(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic note(input int i, input logic [15:0] e);
		q.push_back('{i, e});
	endtask
	// two spare edges let the two-stage flag settle too
	task automatic st(input int k, input logic [1:0] s, input logic [15:0] v,
		input int i, input logic [15:0] e);
		host.cmd(k, s, v);
		w(2);
		note(i, e);
	endtask
	task automatic results();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	always @(negedge ref_clk) begin
		while (q.size() > 0) begin
			nt = q.pop_front();
			compares++;
			if (ob[nt.i] !== nt.e) begin
				bad_count++;
				$display("Error out%0d exp %h seen %h", nt.i, nt.e, ob[nt.i]);
			end
		end
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 2000) begin
			bad_count++;
			results();
		end
	end
	initial begin
		w(8);
		rst = 1'b0;
		st(2, 2'h0, 16'h0001, 0, 16'h0001);
		st(2, 2'h0, 16'h0063, 0, 16'h0063);
		st(2, 2'h0, 16'h0064, 0, 16'h0063);
		dc = 1'b1;
		st(2, 2'h0, 16'h0005, 0, 16'h0063);
		dc = 1'b0;
		for (int m = 5; m >= 0; m--) begin
			st(4, 2'h0, 16'(m), 2, 16'(m % 5));
		end
		foreach (tab[j]) begin
			st(tab[j][15:12], 2'h0, 16'(tab[j][11:8]), tab[j][7:4],
				16'(tab[j][3:0]));
		end
		host.cmd(1, 2'h2, 16'h00C8);
		host.cmd(0, 2'h2, 16'h0064);
		st(0, 2'h2, 16'h012C, 11, 16'h0064);
		for (int n = 0; n < 30; n++) begin
			rn = nx(rn);
			mv = n < 2 ? 16'h0064 + 16'(n * 100) : {8'h00, rn[7:0]};
			w(3);
			note(8, 16'(mv < 16'h0064 || mv > 16'h00C8));
		end
		mv = 16'h0096;
		mc = 16'h0005;
		host.cmd(1, 2'h0, 16'h0014);
		st(0, 2'h0, 16'h000A, 8, 16'h0001);
		mc = 16'h000F;
		st(0, 2'h1, 16'h000A, 8, 16'h0000);
		st(4, 2'h0, 16'h0003, 8, 16'h0001);
		st(4, 2'h0, 16'h0001, 8, 16'h0001);
		st(4, 2'h0, 16'h0002, 8, 16'h0000);
		st(0, 2'h3, 16'h00C8, 8, 16'h0001);
		st(5, 2'h0, 16'h0000, 8, 16'h0000);
		for (int n = 0; n < 3; n++) begin
			rn = nx(rn);
			ev = rn[9:0];
			ef = ef | ev;
			w(1);
			ev = 10'h000;
			note(9, 16'(ef[5:0]));
			note(10, 16'(ef[9:6]));
		end
		st(10, 2'h0, 16'h0000, 9, 16'h0000);
		note(10, 16'h0000);
		w(1);
		results();
	end
endmodule // tb_load_limit_status_monitor
bind llsm_monitor llsm_chk chk (.ref_clk, .rst, .ce, .duty_wr, .duty_data,
	.dimming_rate_dc, .duty_r, .duty_reject_r, .meas_voltage,
	.voltage_lower_bound,
	.voltage_upper_bound, .limit_violation_flag, .fail_lamp_r,
	.flag_wipe_command, .ch1_err_evt, .op_err_evt, .cmd_err_evt,
	.fault_flag_register);
`default_nettype wire
